// ===== core/decrement_file_pkg.sv
package decrement_file_pkg;

    localparam int ADDR_W = 14;
    localparam int BANK_W = 6;

    localparam logic [5:0] DECREMENT_OPCODE = 6'h01;
    localparam logic [5:0] DECREMENT_SKIP_OPCODE = 6'h0b;
    localparam int OPCODE_POS = 10;
    localparam int DEST_POS = 9;
    localparam int BANK_BIT_POS = 8;

    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [5:0] ACCESS_LOW_PAGE = 6'h00;
    localparam logic [5:0] ACCESS_HIGH_PAGE = 6'h3f;
    localparam logic [7:0] ONE = 8'h01;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        PHASE_DECODE = 2'b00,
        PHASE_READ = 2'b01,
        PHASE_PROCESS = 2'b11,
        PHASE_WRITE = 2'b10
    } phase_t;

    typedef struct packed {
        logic is_ours;
        logic is_skip;
        logic dest_file;
        logic [ADDR_W-1:0] addr;
    } decoded_t;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic negative;
        logic overflow_flag;
        logic zero;
    } flags_t;

    localparam decoded_t DECODED_RESET = '{1'b0, 1'b0, 1'b0, 14'h0000};
    localparam flags_t FLAGS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// ===== core/decrement_alu.sv
`timescale 1ns/1ps
module decrement_alu (
    input wire logic [7:0] operand,
    output logic [7:0] result,
    output decrement_file_pkg::flags_t flags
);

    // The subtraction is done as an add of all ones, so carry means no borrow.
    always_comb begin
        result = operand - decrement_file_pkg::ONE;
        flags.carry = (operand != 8'h00);
        flags.digit_carry_flag = (operand[3:0] != 4'h0);
        flags.negative = result[7];
        flags.overflow_flag = (operand == 8'h80);
        flags.zero = (result == 8'h00);
    end

endmodule

// ===== core/decrement_file_instructions.sv
`timescale 1ns/1ps
module decrement_file_instructions (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    input wire logic [decrement_file_pkg::BANK_W-1:0] bank_select_register,
    input wire logic extended_set_enable,
    input wire logic [decrement_file_pkg::ADDR_W-1:0] index_base,
    output logic [decrement_file_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_rd_en,
    input wire logic [7:0] mem_rd_data,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    output logic accum_wr_en,
    output logic [7:0] accum_wr_data,
    output logic status_wr_en,
    output decrement_file_pkg::flags_t status_flags,
    output logic skip_next
);

    decrement_file_pkg::phase_t phase_reg;
    decrement_file_pkg::phase_t phase_next;
    decrement_file_pkg::decoded_t decoded_reg;
    decrement_file_pkg::decoded_t decoded_next;
    decrement_file_pkg::decoded_t decoded_now;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    decrement_file_pkg::flags_t flags_reg;
    decrement_file_pkg::flags_t flags_next;
    logic mem_rd_en_reg;
    logic mem_rd_en_next;
    logic mem_wr_en_reg;
    logic mem_wr_en_next;
    logic accum_wr_en_reg;
    logic accum_wr_en_next;
    logic status_wr_en_reg;
    logic status_wr_en_next;
    logic skip_reg;
    logic skip_next_val;
    logic [7:0] alu_result;
    decrement_file_pkg::flags_t alu_flags;
    logic [5:0] opcode;
    logic [7:0] file_addr;
    logic bank_bit;
    logic is_plain_now;
    logic is_skip_now;
    logic indexed_hit;
    logic high_half;
    logic [decrement_file_pkg::ADDR_W-1:0] addr_now;
    logic take;
    logic process_ours;

    decrement_alu alu (
        .operand(mem_rd_data),
        .result(alu_result),
        .flags(alu_flags)
    );

    assign opcode = instr_word[15:decrement_file_pkg::OPCODE_POS];
    assign file_addr = instr_word[7:0];
    assign bank_bit = instr_word[decrement_file_pkg::BANK_BIT_POS];
    assign instr_ready = (phase_reg == decrement_file_pkg::PHASE_DECODE);
    assign take = instr_valid && instr_ready;
    assign process_ours = (phase_reg == decrement_file_pkg::PHASE_PROCESS)
        && decoded_reg.is_ours;
    assign is_plain_now = (opcode == decrement_file_pkg::DECREMENT_OPCODE);
    assign is_skip_now = (opcode == decrement_file_pkg::DECREMENT_SKIP_OPCODE);
    assign indexed_hit = extended_set_enable
        && (file_addr <= decrement_file_pkg::INDEXED_LIMIT);
    assign high_half = (file_addr >= decrement_file_pkg::ACCESS_SPLIT);

    // Opcode decode of the fetched word.
    always_comb begin
        decoded_now = decrement_file_pkg::DECODED_RESET;
        decoded_now.is_ours = is_plain_now || is_skip_now;
        decoded_now.is_skip = is_skip_now;
        decoded_now.dest_file = instr_word[decrement_file_pkg::DEST_POS];
        decoded_now.addr = addr_now;
    end

    // Effective address for the banked, indexed and access bank forms.
    always_comb begin
        case ({bank_bit, indexed_hit, high_half})
            3'b100, 3'b101, 3'b110, 3'b111: begin
                addr_now = {bank_select_register, file_addr};
            end
            3'b010, 3'b011: begin
                addr_now = index_base + {6'h00, file_addr};
            end
            3'b001: begin
                addr_now = {decrement_file_pkg::ACCESS_HIGH_PAGE, file_addr};
            end
            default: begin
                addr_now = {decrement_file_pkg::ACCESS_LOW_PAGE, file_addr};
            end
        endcase
    end

    // Four-phase instruction cycle: decode, read, process and write.
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            decrement_file_pkg::PHASE_DECODE: begin
                if (take) begin
                    phase_next = decrement_file_pkg::PHASE_READ;
                end
            end
            decrement_file_pkg::PHASE_READ: begin
                phase_next = decrement_file_pkg::PHASE_PROCESS;
            end
            decrement_file_pkg::PHASE_PROCESS: begin
                phase_next = decrement_file_pkg::PHASE_WRITE;
            end
            decrement_file_pkg::PHASE_WRITE: begin
                phase_next = decrement_file_pkg::PHASE_DECODE;
            end
            default: begin
                phase_next = decrement_file_pkg::PHASE_DECODE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= decrement_file_pkg::PHASE_DECODE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // The decoded word is held from its decode phase until the next word is taken.
    always_comb begin
        decoded_next = decoded_reg;
        if (take) begin
            decoded_next = decoded_now;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            decoded_reg <= decrement_file_pkg::DECODED_RESET;
        end else begin
            decoded_reg <= decoded_next;
        end
    end

    // The decremented value is captured in the process phase.
    always_comb begin
        result_next = result_reg;
        if (process_ours) begin
            result_next = alu_result;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_reg <= decrement_file_pkg::DATA_RESET;
        end else begin
            result_reg <= result_next;
        end
    end

    // The status flags follow the plain decrement only.
    always_comb begin
        flags_next = flags_reg;
        if (process_ours && !decoded_reg.is_skip) begin
            flags_next = alu_flags;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= decrement_file_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // The read strobe is a one-cycle pulse in the read phase.
    always_comb begin
        mem_rd_en_next = 1'b0;
        if (take) begin
            mem_rd_en_next = decoded_now.is_ours;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_rd_en_reg <= 1'b0;
        end else begin
            mem_rd_en_reg <= mem_rd_en_next;
        end
    end

    // The write strobes are one-cycle pulses in the write phase.
    always_comb begin
        mem_wr_en_next = 1'b0;
        accum_wr_en_next = 1'b0;
        status_wr_en_next = 1'b0;
        skip_next_val = 1'b0;
        if (process_ours) begin
            mem_wr_en_next = decoded_reg.dest_file;
            accum_wr_en_next = !decoded_reg.dest_file;
            status_wr_en_next = !decoded_reg.is_skip;
            skip_next_val = decoded_reg.is_skip && alu_flags.zero;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_wr_en_reg <= 1'b0;
            accum_wr_en_reg <= 1'b0;
            status_wr_en_reg <= 1'b0;
            skip_reg <= 1'b0;
        end else begin
            mem_wr_en_reg <= mem_wr_en_next;
            accum_wr_en_reg <= accum_wr_en_next;
            status_wr_en_reg <= status_wr_en_next;
            skip_reg <= skip_next_val;
        end
    end

    assign mem_addr = decoded_reg.addr;
    assign mem_rd_en = mem_rd_en_reg;
    assign mem_wr_en = mem_wr_en_reg;
    assign mem_wr_data = result_reg;
    assign accum_wr_en = accum_wr_en_reg;
    assign accum_wr_data = result_reg;
    assign status_wr_en = status_wr_en_reg;
    assign status_flags = flags_reg;
    assign skip_next = skip_reg;

endmodule

// ===== tb/decrement_file_props.sv
`timescale 1ns/1ps
module decrement_file_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic instr_ready,
    input wire logic [5:0] bank_select_register,
    input wire logic extended_set_enable,
    input wire logic [13:0] index_base,
    input wire logic [13:0] mem_addr,
    input wire logic mem_rd_en,
    input wire logic [7:0] mem_rd_data,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wr_data,
    input wire logic accum_wr_en,
    input wire logic [7:0] accum_wr_data,
    input wire logic status_wr_en,
    input wire logic skip_next
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire take = instr_valid && instr_ready;
    wire [7:0] f = instr_word[7:0];
    wire d = instr_word[9];
    wire a = instr_word[8];
    wire plain = instr_word[15:10] == 6'h01;
    wire skipv = instr_word[15:10] == 6'h0b;
    wire ours = plain || skipv;
    wire idx = extended_set_enable && f <= 8'h5f;
    wire any_wr = mem_wr_en || accum_wr_en || status_wr_en || skip_next;
    wire [7:0] res = mem_wr_en ? mem_wr_data : accum_wr_data;
    a_ready_gap: assert property (take |=> !instr_ready [*3] ##1 instr_ready)
        else $error("ready gap wrong");
    a_read_strobe: assert property (take && ours |=> mem_rd_en ##1 !mem_rd_en)
        else $error("read strobe wrong");
    a_foreign_quiet: assert property (take && !ours |=> (!mem_rd_en && !any_wr) [*3])
        else $error("foreign opcode strobed");
    a_dest_select: assert property (take && ours |-> ##3 mem_wr_en == $past(d, 3)
        && accum_wr_en != $past(d, 3)) else $error("destination wrong");
    a_bank_addr: assert property (take && ours && a
        |=> mem_addr == {$past(bank_select_register), $past(f)}) else $error("bank addr wrong");
    a_access_addr: assert property (take && ours && !a && !idx
        |=> mem_addr == {$past(f) < 8'h60 ? 6'h00 : 6'h3f, $past(f)})
        else $error("access addr wrong");
    a_indexed_addr: assert property (take && ours && !a && idx
        |=> mem_addr == $past(index_base) + 14'($past(f))) else $error("indexed addr wrong");
    a_result_value: assert property (mem_rd_en |-> ##2 res == $past(mem_rd_data) - 8'h01)
        else $error("result wrong");
    a_skip_zero: assert property (take && skipv |-> ##3 (skip_next == (res == 8'h00))
        && !status_wr_en) else $error("skip wrong");
    a_plain_flags: assert property (take && plain |-> ##3 status_wr_en && !skip_next)
        else $error("status strobe wrong");
endmodule
bind decrement_file_instructions decrement_file_props props (.*);

// ===== tb/data_memory_model.sv
`timescale 1ns/1ps
module data_memory_model (
    input wire logic clk,
    input wire logic [13:0] mem_addr,
    input wire logic mem_rd_en,
    output logic [7:0] mem_rd_data,
    input wire logic mem_wr_en,
    input wire logic [7:0] mem_wr_data
);
    logic [7:0] mem [0:16383];
    initial begin
        for (int i = 0; i < 16384; i++) mem[i] = {i[0], 4'h0, i[3:1]};
    end
    // Data is valid only in the cycle after the read strobe; otherwise it toggles.
    always @(posedge clk) begin
        mem_rd_data <= mem_rd_en ? mem[mem_addr] : ~mem_rd_data;
        if (mem_wr_en) mem[mem_addr] <= mem_wr_data;
    end
endmodule

// ===== tb/decrement_file_instructions_tb.sv
`timescale 1ns/1ps
module decrement_file_instructions_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [5:0] bank_select_register = 6'h00;
    logic extended_set_enable = 1'b0;
    logic [13:0] index_base = 14'h0000;
    logic instr_ready, mem_rd_en, mem_wr_en, accum_wr_en, status_wr_en, skip_next;
    logic [13:0] mem_addr;
    logic [7:0] mem_rd_data, mem_wr_data, accum_wr_data;
    decrement_file_pkg::flags_t status_flags;
    logic [31:0] q [$];
    logic [31:0] seen, e;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 11;
    logic hung = 1'b0;
    always #10 clk = ~clk;
    decrement_file_instructions DUT (.*);
    data_memory_model mdl (.*);
    task automatic summarize;
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [13:0] ea(logic [15:0] w, logic [5:0] b, logic x, logic [13:0] ib);
        if (w[8]) return {b, w[7:0]};
        if (x && w[7:0] <= 8'h5f) return ib + 14'(w[7:0]);
        return {w[7:0] < 8'h60 ? 6'h00 : 6'h3f, w[7:0]};
    endfunction
    task automatic issue(input logic [15:0] w);
        logic [13:0] a;
        logic [7:0] v, r;
        int i;
        instr_valid <= 1'b1;
        instr_word <= w;
        bank_select_register <= 6'($random(seed));
        extended_set_enable <= 1'($random(seed));
        index_base <= 14'($random(seed));
        @(negedge clk);
        for (i = 0; i < 8 && instr_ready !== 1'b1; i++) @(negedge clk);
        if (i == 8) begin
            err_total++;
            $display("mismatch instr_ready expected 1 seen %b", instr_ready);
            hung = 1'b1;
            return;
        end
        a = ea(w, bank_select_register, extended_set_enable, index_base);
        v = mdl.mem[a];
        r = v - 8'h01;
        if (w[15:10] == 6'h01 || w[15:10] == 6'h0b)
            q.push_back({a, w[9], !w[9], r, w[15:10] == 6'h01, w[15:10] == 6'h0b && r == 8'h00,
                w[15:10] == 6'h01 ? {v != 0, v[3:0] != 0, r[7], v == 8'h80, r == 0} : 5'h00});
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        #1;
        if (mem_wr_en === 1'b1 || accum_wr_en === 1'b1) begin
            seen = {mem_addr, mem_wr_en, accum_wr_en, mem_wr_en ? mem_wr_data : accum_wr_data,
                status_wr_en, skip_next, status_wr_en ? status_flags : 5'h00};
            e = q.size() > 0 ? q.pop_front() : 32'hxxxxxxxx;
            samples_checked++;
            if (seen !== e) begin
                err_total++;
                $display("mismatch result expected %h seen %h", e, seen);
            end
        end
    end
    initial begin
        logic [15:0] w;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 200 && !hung; k++) begin
            w = 16'($random(seed));
            if (k % 4 < 2) w[15:10] = 6'h01;
            else if (k % 4 == 2) w[15:10] = 6'h0b;
            if (k % 8 == 0) w[7:0] = 8'h5f + 8'(k[3]);
            if (k % 8 == 1) w[8:0] = 9'h061;
            if (k % 8 == 2) w[8:0] = 9'h062;
            issue(w);
        end
        instr_valid <= 1'b0;
        repeat (6) @(posedge clk);
        if (q.size() != 0) begin
            err_total++;
            $display("mismatch queue expected 0 seen %0d", q.size());
        end
        summarize();
    end
endmodule
